// ### design/row_alert_top.sv
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module row_alert_top
  import row_alert_pkg::*;
#(
  parameter longint unsigned SAMPLE_RATE_HZ  = REF_RATE_HZ,
  parameter int unsigned     ROW_HIGH_CYCLES = int'(ROW_HIGH_CYC_REF * REF_RATE_HZ / SAMPLE_RATE_HZ),
  parameter int unsigned     ROW_LOW_CYCLES  = int'(ROW_LOW_CYC_REF * REF_RATE_HZ / SAMPLE_RATE_HZ),
  parameter int unsigned     SCAN_HIGH_CYCLES = int'(SCAN_HIGH_CYC_REF * REF_RATE_HZ / SAMPLE_RATE_HZ),
  parameter int unsigned     SCAN_LOW_CYCLES = int'(SCAN_LOW_CYC_REF * REF_RATE_HZ / SAMPLE_RATE_HZ)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic [ADDR_W-1:0]       avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [DATA_W-1:0]       avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [DATA_W-1:0]            avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    ss_b,
  input  wire logic                    op_record,
  input  wire logic                    op_play,
  input  wire logic                    op_start,
  input  wire logic                    last_row,
  input  wire logic [MARKER_SLOTS-1:0] marker_bits,
  output logic                         row_address_clock_out,
  output logic                         row_address_clock_oe,
  output logic                         alert_out,
  output logic                         alert_oe,
  output logic                         row_end,
  output logic                         op_stop,
  output logic [NUM_FLAGS-1:0]         status_word
);

  // ---------------------------------------------------------------
  // Row timing counts
  // ---------------------------------------------------------------
  // Counts are derived from the sample rate so slower parts stretch
  localparam logic [CNT_W-1:0] HIGH_N      = CNT_W'(ROW_HIGH_CYCLES);
  localparam logic [CNT_W-1:0] LOW_N       = CNT_W'(ROW_LOW_CYCLES);
  localparam logic [CNT_W-1:0] SCAN_HIGH_N = CNT_W'(SCAN_HIGH_CYCLES);
  localparam logic [CNT_W-1:0] SCAN_LOW_N  = CNT_W'(SCAN_LOW_CYCLES);
  localparam logic [CNT_W-1:0] SLOT_N      = CNT_W'((ROW_HIGH_CYCLES + ROW_LOW_CYCLES)
                                                    / MARKER_SLOTS);
  localparam logic [CNT_W-1:0] SCAN_SLOT_N = CNT_W'((SCAN_HIGH_CYCLES + SCAN_LOW_CYCLES)
                                                    / MARKER_SLOTS);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                     ack_reg;
  logic [DATA_W-1:0]        readdata_reg;
  logic                     scan_reg;
  logic [MARKER_SLOTS-1:0]  mask_reg;
  logic [ROWS_W-1:0]        rows_reg;
  logic [NUM_FLAGS-1:0]     snapshot_reg;
  logic                     ss_prev_reg;
  logic                     running_reg;
  logic [NUM_FLAGS-1:0]     flags;
  logic [NUM_FLAGS-1:0]     flag_set;
  logic                     row_low;
  logic                     slot_end;
  logic [SLOT_W-1:0]        slot_idx;
  logic [DATA_W-1:0]        rd_mux;
  logic [DATA_W-1:0]        status_val;
  wire                      req;
  wire                      wr_en;
  wire                      rd_take;
  wire                      sel_control;
  wire                      sel_status;
  wire                      sel_rows;
  wire                      sel_snapshot;
  wire                      sel_mask;
  wire                      sw_clear;
  wire                      cycle_start;
  wire                      flag_clear;
  wire                      op_active;
  wire                      alert_pending;
  wire                      mem_end_event;
  wire                      msg_end_event;
  wire [CNT_W-1:0]          high_sel;
  wire [CNT_W-1:0]          low_sel;
  wire [CNT_W-1:0]          slot_sel;

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ---------------------------------------------------------------
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_en           = avs_write & ack_reg;
  assign rd_take         = avs_read & ~ack_reg;
  assign avs_readdata    = readdata_reg;

  assign sel_control  = (avs_address == CONTROL_OFS);
  assign sel_status   = (avs_address == STATUS_OFS);
  assign sel_rows     = (avs_address == ROW_COUNT_OFS);
  assign sel_snapshot = (avs_address == SNAPSHOT_OFS);
  assign sel_mask     = (avs_address == MARKER_MASK_OFS);

  assign sw_clear = wr_en & sel_control & avs_byteenable[0] & avs_writedata[CTRL_CLEAR_BIT];

  always_comb begin
    status_val                              = '0;
    status_val[ST_ALERT_BIT]                = alert_pending;
    status_val[ST_MEM_END_BIT]              = flags[FLAG_MEM_END];
    status_val[ST_MSG_END_BIT]              = flags[FLAG_MSG_END];
    status_val[ST_ROW_CLK_BIT]              = ~row_low;
    status_val[ST_BUSY_BIT]                 = op_active;
    status_val[ST_SLOT_LSB +: SLOT_W]       = slot_idx;
  end

  always_comb begin
    rd_mux = '0;
    if (sel_control) begin
      rd_mux[CTRL_SCAN_BIT] = scan_reg;
    end else if (sel_status) begin
      rd_mux = status_val;
    end else if (sel_rows) begin
      rd_mux[ROWS_W-1:0] = rows_reg;
    end else if (sel_snapshot) begin
      rd_mux[NUM_FLAGS-1:0] = snapshot_reg;
    end else if (sel_mask) begin
      rd_mux[MARKER_SLOTS-1:0] = mask_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_reg <= '0;
    end else if (rd_take) begin
      readdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scan_reg <= SCAN_RESET;
    end else if (wr_en && sel_control && avs_byteenable[0]) begin
      scan_reg <= avs_writedata[CTRL_SCAN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= MASK_RESET;
    end else if (wr_en && sel_mask && avs_byteenable[0]) begin
      mask_reg <= avs_writedata[MARKER_SLOTS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Row timing
  // ---------------------------------------------------------------
  assign op_active = op_record | op_play;
  assign high_sel  = scan_reg ? SCAN_HIGH_N : HIGH_N;
  assign low_sel   = scan_reg ? SCAN_LOW_N : LOW_N;
  assign slot_sel  = scan_reg ? SCAN_SLOT_N : SLOT_N;

  row_timer u_row_timer (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .run         (running_reg),
    .start       (op_start),
    .record      (op_record),
    .high_cycles (high_sel),
    .low_cycles  (low_sel),
    .slot_cycles (slot_sel),
    .row_low     (row_low),
    .row_end     (row_end),
    .slot_end    (slot_end),
    .slot_idx    (slot_idx)
  );

  // An operation ends itself as soon as it raises an alert
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= op_active & (op_start | (running_reg & ~op_stop));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rows_reg <= '0;
    end else if (op_start) begin
      rows_reg <= '0;
    end else if (row_end) begin
      rows_reg <= rows_reg + ROWS_W'(1);
    end
  end

  // Only the low level is ever driven, the pull-up makes the high
  assign row_address_clock_out = 1'b0;
  assign row_address_clock_oe  = row_low;

  // ---------------------------------------------------------------
  // Alert flags and serial cycle
  // ---------------------------------------------------------------
  assign mem_end_event = running_reg & row_end & last_row;
  assign msg_end_event = running_reg & op_play & ~op_record & slot_end
                         & marker_bits[slot_idx] & mask_reg[slot_idx];
  assign flag_set[FLAG_MEM_END] = mem_end_event;
  assign flag_set[FLAG_MSG_END] = msg_end_event;
  assign op_stop = mem_end_event | msg_end_event;

  // A serial cycle can only begin with the select going low
  assign cycle_start = ss_prev_reg & ~ss_b;
  assign flag_clear  = cycle_start | sw_clear;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_prev_reg <= 1'b1;
    end else begin
      ss_prev_reg <= ss_b;
    end
  end

  alert_flags #(
    .N (NUM_FLAGS)
  ) u_alert_flags (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .set     (flag_set),
    .clear   (flag_clear),
    .flags   (flags)
  );

  // The status instruction shifts the flags held at cycle start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      snapshot_reg <= '0;
    end else if (cycle_start) begin
      snapshot_reg <= flags;
    end
  end

  assign status_word   = snapshot_reg;
  assign alert_pending = |flags;
  assign alert_out     = 1'b0;
  assign alert_oe      = alert_pending;

endmodule
`default_nettype wire

// ### design/row_alert_pkg.sv
`default_nettype none
package row_alert_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_PS     = 64'd8000;
  localparam longint unsigned REF_RATE_HZ       = 64'd8000;
  localparam longint unsigned ROW_HIGH_TIME_PS  = 64'd175000000000;
  localparam longint unsigned ROW_LOW_TIME_PS   = 64'd25000000000;
  localparam longint unsigned SCAN_HIGH_TIME_PS = 64'd109370000;
  localparam longint unsigned SCAN_LOW_TIME_PS  = 64'd15630000;
  localparam longint unsigned ROW_HIGH_CYC_REF  = ROW_HIGH_TIME_PS / CLK_PERIOD_PS;
  localparam longint unsigned ROW_LOW_CYC_REF   = ROW_LOW_TIME_PS / CLK_PERIOD_PS;
  localparam longint unsigned SCAN_HIGH_CYC_REF = SCAN_HIGH_TIME_PS / CLK_PERIOD_PS;
  localparam longint unsigned SCAN_LOW_CYC_REF  = SCAN_LOW_TIME_PS / CLK_PERIOD_PS;

  localparam int unsigned CNT_W        = 32;
  localparam int unsigned MARKER_SLOTS = 8;
  localparam int unsigned SLOT_W       = 3;
  localparam int unsigned ROWS_W       = 16;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CONTROL_OFS     = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS      = 5'h04;
  localparam logic [ADDR_W-1:0] ROW_COUNT_OFS   = 5'h08;
  localparam logic [ADDR_W-1:0] SNAPSHOT_OFS    = 5'h0c;
  localparam logic [ADDR_W-1:0] MARKER_MASK_OFS = 5'h10;

  localparam int unsigned CTRL_SCAN_BIT  = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned ST_ALERT_BIT   = 0;
  localparam int unsigned ST_MEM_END_BIT = 1;
  localparam int unsigned ST_MSG_END_BIT = 2;
  localparam int unsigned ST_ROW_CLK_BIT = 3;
  localparam int unsigned ST_BUSY_BIT    = 4;
  localparam int unsigned ST_SLOT_LSB    = 8;

  localparam logic                    SCAN_RESET = 1'b0;
  localparam logic [MARKER_SLOTS-1:0] MASK_RESET = 8'hff;

  // ---------------------------------------------------------------
  // Alert flags
  // ---------------------------------------------------------------
  localparam int unsigned NUM_FLAGS    = 2;
  localparam int unsigned FLAG_MEM_END = 0;
  localparam int unsigned FLAG_MSG_END = 1;

  typedef enum logic [1:0] {
    ROW_IDLE  = 2'b00,
    ROW_EXTRA = 2'b01,
    ROW_HIGH  = 2'b10,
    ROW_LOW   = 2'b11
  } row_state_t;

endpackage
`default_nettype wire

// ### design/row_timer.sv
`timescale 1ns/1ps
`default_nettype none
module row_timer
  import row_alert_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              run,
  input  wire logic              start,
  input  wire logic              record,
  input  wire logic [CNT_W-1:0]  high_cycles,
  input  wire logic [CNT_W-1:0]  low_cycles,
  input  wire logic [CNT_W-1:0]  slot_cycles,
  output logic                   row_low,
  output logic                   row_end,
  output logic                   slot_end,
  output logic [SLOT_W-1:0]      slot_idx
);

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  row_state_t         state_reg;
  row_state_t         state_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [CNT_W-1:0]   slot_cnt_reg;
  logic [CNT_W-1:0]   slot_cnt_next;
  logic [SLOT_W-1:0]  slot_idx_reg;
  logic [SLOT_W-1:0]  slot_idx_next;
  logic [CNT_W-1:0]   phase_len;
  wire                in_row;
  wire                phase_done;
  wire                slot_done;
  wire                begin_op;
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(MARKER_SLOTS - 1);

  // Extra phase lasts one low-phase time while still high
  assign phase_len  = (state_reg == ROW_HIGH) ? high_cycles : low_cycles;
  // A mode change mid-phase must not skip the end of the phase
  assign phase_done = (cnt_reg >= phase_len - CNT_W'(1));
  assign in_row     = (state_reg == ROW_HIGH) || (state_reg == ROW_LOW);
  assign row_end    = run && !start && (state_reg == ROW_LOW) && phase_done;
  assign slot_done  = row_end ||
                      ((slot_cnt_reg >= slot_cycles - CNT_W'(1)) && (slot_idx_reg != LAST_SLOT));
  assign slot_end   = run && !start && in_row && slot_done;
  assign begin_op   = start || (state_reg == ROW_IDLE);
  assign row_low    = (state_reg == ROW_LOW);
  assign slot_idx   = slot_idx_reg;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg + CNT_W'(1);
    slot_cnt_next = slot_cnt_reg;
    slot_idx_next = slot_idx_reg;
    if (!run) begin
      state_next    = ROW_IDLE;
      cnt_next      = '0;
      slot_cnt_next = '0;
      slot_idx_next = '0;
    end else if (begin_op) begin
      state_next    = record ? ROW_EXTRA : ROW_HIGH;
      cnt_next      = '0;
      slot_cnt_next = '0;
      slot_idx_next = '0;
    end else begin
      case (state_reg)
        ROW_EXTRA: begin
          if (phase_done) begin
            state_next = ROW_HIGH;
            cnt_next   = '0;
          end
        end
        ROW_HIGH: begin
          if (phase_done) begin
            state_next = ROW_LOW;
            cnt_next   = '0;
          end
        end
        ROW_LOW: begin
          if (phase_done) begin
            state_next = ROW_HIGH;
            cnt_next   = '0;
          end
        end
        default: begin
          state_next = ROW_IDLE;
          cnt_next   = '0;
        end
      endcase
      if (in_row) begin
        if (slot_done) begin
          slot_cnt_next = '0;
          slot_idx_next = row_end ? '0 : slot_idx_reg + SLOT_W'(1);
        end else begin
          slot_cnt_next = slot_cnt_reg + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ROW_IDLE;
      cnt_reg      <= '0;
      slot_cnt_reg <= '0;
      slot_idx_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      slot_cnt_reg <= slot_cnt_next;
      slot_idx_reg <= slot_idx_next;
    end
  end

endmodule
`default_nettype wire

// ### design/alert_flags.sv
`timescale 1ns/1ps
`default_nettype none
module alert_flags
  import row_alert_pkg::*;
#(
  parameter int unsigned N = NUM_FLAGS
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_b,
  input  wire logic [N-1:0]  set,
  input  wire logic          clear,
  output logic [N-1:0]       flags
);

  // ---------------------------------------------------------------
  // Sticky flags, a new event beats a clear in the same cycle
  // ---------------------------------------------------------------
  logic [N-1:0] flag_reg;

  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        flag_reg[i] <= 1'b0;
      end else begin
        flag_reg[i] <= set[i] | (flag_reg[i] & ~clear);
      end
    end
  end

  assign flags = flag_reg;

endmodule
`default_nettype wire

// ### test/row_alert_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module row_alert_asserts
  import row_alert_pkg::*;
#(
  parameter int unsigned ROW_LOW_CYCLES = 8
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_b,
  input wire logic                 avs_write,
  input wire logic                 ss_b,
  input wire logic                 op_record,
  input wire logic                 op_play,
  input wire logic                 last_row,
  input wire logic                 row_address_clock_out,
  input wire logic                 row_address_clock_oe,
  input wire logic                 alert_out,
  input wire logic                 alert_oe,
  input wire logic                 row_end,
  input wire logic                 op_stop,
  input wire logic [NUM_FLAGS-1:0] status_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  pins_drive_low_a: assert property (!row_address_clock_out && !alert_out)
    else $error("open drain data not low");
  row_end_low_a: assert property (row_end |-> row_address_clock_oe ##1 !row_address_clock_oe)
    else $error("row end not at last low cycle");
  // A stopped operation may cut the low phase short, so only its end is bounded
  low_bound_a: assert property ($rose(row_address_clock_oe) |-> ##[1:ROW_LOW_CYCLES] !row_address_clock_oe)
    else $error("low phase too long");
  mem_end_stop_a: assert property ((row_end && last_row && (op_record || op_play)) |-> op_stop)
    else $error("memory end did not stop");
  rec_no_msg_a: assert property ((op_record && !(row_end && last_row)) |-> !op_stop)
    else $error("stop during record without memory end");
  alert_raise_a: assert property (op_stop |=> alert_oe)
    else $error("alert not raised");
  alert_hold_a: assert property ((alert_oe && !$fell(ss_b) && !avs_write) |=> alert_oe)
    else $error("alert dropped without clear");
  alert_clear_a: assert property (($fell(ss_b) && !op_stop) |=> !alert_oe)
    else $error("alert not cleared by select");
  snap_alert_a: assert property ($fell(ss_b) |=> ((|status_word) == $past(alert_oe)))
    else $error("snapshot differs from alert");
endmodule

bind row_alert_top row_alert_asserts #(.ROW_LOW_CYCLES(ROW_LOW_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_write(avs_write), .ss_b(ss_b),
  .op_record(op_record), .op_play(op_play), .last_row(last_row),
  .row_address_clock_out(row_address_clock_out), .row_address_clock_oe(row_address_clock_oe),
  .alert_out(alert_out), .alert_oe(alert_oe), .row_end(row_end), .op_stop(op_stop),
  .status_word(status_word)
);
`default_nettype wire

// ### test/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int unsigned SEL_CYCLES = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic go,
  output logic      ss_b
);
  int unsigned cnt;

  // Select is held low for a whole serial cycle, then released
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_b <= 1'b1;
      cnt  <= 0;
    end else if (cnt != 0) begin
      cnt  <= cnt - 1;
      ss_b <= (cnt == 1);
    end else if (go) begin
      ss_b <= 1'b0;
      cnt  <= SEL_CYCLES;
    end
  end
endmodule
`default_nettype wire

// ### test/row_timing_and_alert_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module row_timing_and_alert_flags_tb;
  import row_alert_pkg::*;
  logic        sys_clk, rst_b, avs_read, avs_write, op_record, op_play, op_start;
  logic        last_row, host_go, avs_waitrequest, ss_b, rac_oe, rac_out;
  logic        al_oe, al_out, row_end, op_stop;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  marker_bits;
  logic [1:0]  status_word;
  int          error_cnt, n_tests, hp, n, t, t0;
  wire         rac_pin   = rac_oe ? rac_out : 1'b1;
  wire         alert_pin = al_oe ? al_out : 1'b1;

  row_alert_top #(.ROW_HIGH_CYCLES(40), .ROW_LOW_CYCLES(8), .SCAN_HIGH_CYCLES(14),
    .SCAN_LOW_CYCLES(2)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ss_b(ss_b),
    .op_record(op_record), .op_play(op_play), .op_start(op_start), .last_row(last_row),
    .marker_bits(marker_bits), .row_address_clock_out(rac_out),
    .row_address_clock_oe(rac_oe), .alert_out(al_out), .alert_oe(al_oe),
    .row_end(row_end), .op_stop(op_stop), .status_word(status_word));
  spi_host_model host (.sys_clk(sys_clk), .rst_b(rst_b), .go(host_go), .ss_b(ss_b));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int   k;
    logic wt;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    // Settled view before each edge, acted on at that edge
    do begin
      @(negedge sys_clk);
      wt = avs_waitrequest;
      q = avs_readdata;
      @(posedge sys_clk);
      k++;
    end while (wt !== 1'b0 && k < 100);
    chk("bus answer", 1, k < 100);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Called at a negedge; the first other level seen is left for the next call
  task automatic meas(input logic lvl, output int c);
    c = 0;
    while (rac_pin === lvl && c < 1000) begin
      c++;
      @(negedge sys_clk);
    end
  endtask
  task automatic start_op(input logic rec);
    @(posedge sys_clk);
    op_record <= rec;
    op_play <= !rec;
    op_start <= 1'b1;
    @(posedge sys_clk);
    op_start <= 1'b0;
  endtask
  task automatic stop_op();
    @(posedge sys_clk);
    op_record <= 1'b0;
    op_play <= 1'b0;
    last_row <= 1'b0;
    marker_bits <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wait_stop(output int c);
    c = 0;
    @(negedge sys_clk);
    while (op_stop !== 1'b1 && c < 500) begin
      c++;
      @(negedge sys_clk);
    end
  endtask
  task automatic select_host();
    @(posedge sys_clk);
    host_go <= 1'b1;
    @(posedge sys_clk);
    host_go <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    bus(0, CONTROL_OFS, 0);
    chk("control reset", 0, q);
    bus(0, MARKER_MASK_OFS, 0);
    chk("mask reset", {24'h0, MASK_RESET}, q);
    bus(1, 5'h14, 32'hff);
    bus(0, 5'h14, 0);
    chk("unmapped", 0, q);
  endtask
  task automatic t_play();
    start_op(0);
    @(negedge sys_clk);
    meas(1, hp);
    chk("play lead", 41, hp);
    meas(0, n);
    chk("low time", 8, n);
    meas(1, n);
    chk("high time", 40, n);
    meas(0, n);
    chk("low time 2", 8, n);
    bus(0, ROW_COUNT_OFS, 0);
    chk("row count", 2, q);
    last_row <= 1'b1;
    wait_stop(t);
    chk("mem end stop", 1, t < 49);
    @(negedge sys_clk);
    chk("alert low", 0, alert_pin);
    stop_op();
    repeat (10) @(posedge sys_clk);
    chk("alert held", 0, alert_pin);
    bus(0, STATUS_OFS, 0);
    chk("mem flag", 1, q[ST_MEM_END_BIT]);
    select_host();
    chk("alert released", 1, alert_pin);
    bus(0, SNAPSHOT_OFS, 0);
    chk("snapshot", 1, q);
  endtask
  task automatic t_record();
    marker_bits <= 8'hff;
    start_op(1);
    @(negedge sys_clk);
    meas(1, n);
    chk("record lead", 49, n);
    t = 0;
    repeat (100) begin
      @(negedge sys_clk);
      if (op_stop === 1'b1) t++;
    end
    chk("no msg end in record", 0, t);
    @(posedge sys_clk);
    last_row <= 1'b1;
    wait_stop(t);
    @(negedge sys_clk);
    chk("record alert", 0, alert_pin);
    stop_op();
    select_host();
    bus(0, SNAPSHOT_OFS, 0);
    chk("record snapshot", 1, q);
  endtask
  task automatic t_scan();
    bus(1, CONTROL_OFS, 1);
    start_op(0);
    @(negedge sys_clk);
    meas(1, n);
    meas(0, n);
    chk("scan low", 2, n);
    meas(1, n);
    chk("scan high", 14, n);
    stop_op();
    bus(1, CONTROL_OFS, 0);
  endtask
  task automatic t_marker();
    for (int k = 0; k < 8; k++) begin
      marker_bits <= 8'h01 << k;
      start_op(0);
      wait_stop(t);
      if (k == 0) begin
        t0 = t;
      end
      chk("slot offset", 6 * k, t - t0);
      stop_op();
      bus(0, STATUS_OFS, 0);
      chk("msg flag", 1, q[ST_MSG_END_BIT]);
      bus(1, CONTROL_OFS, 2);
    end
  endtask

  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #50us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_b, avs_read, avs_write, op_record, op_play, op_start, last_row, host_go} = '0;
    avs_address = '0;
    avs_writedata = '0;
    marker_bits = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_play();
    t_record();
    t_scan();
    t_marker();
    wrap_up();
  end
endmodule
`default_nettype wire
